// *** common/pes_consts.svh ***
// Constants of the precise event sampling unit
`ifndef PES_CONSTS_SVH
`define PES_CONSTS_SVH

`define PES_NUM_CNT       4
`define PES_NUM_GPR       16
`define PES_CNT_W         48
`define PES_DATA_W        64
`define PES_ADDR_W        48
`define PES_SEL_W         8
`define PES_RECCNT_W      16

// Event selection codes
`define PES_CODE_MEM_INST 8'h0B
`define PES_CODE_LD_RET   8'hCB
`define PES_CODE_STORE    8'h0C
`define PES_CODE_UNCORE   8'h0F
`define PES_CODE_ITLB     8'hC8

// Unit-mask bits of the retired load category
`define PES_LD_L1_HIT     8'h01
`define PES_LD_L2_HIT     8'h02
`define PES_LD_L3_NOSNP   8'h04
`define PES_LD_L3_SNP     8'h08
`define PES_LD_L3_MISS    8'h10
`define PES_LD_LFB_HIT    8'h40
`define PES_LD_DTLB_MISS  8'h80

// Unit-mask bits of the uncore category
`define PES_UNC_LOCAL     8'h01
`define PES_UNC_REMOTE    8'h02

// Unit-mask bit for loads of the memory instruction category
`define PES_INST_LOADS    8'h01

// Record layout: status word, next ip, sixteen registers
`define PES_REC_WORDS     18
`define PES_WORD_BYTES    8
`define PES_REC_BYTES     (`PES_REC_WORDS * `PES_WORD_BYTES)
`define PES_WIDX_W        5
`define PES_WIDX_LAST     5'd17

`endif

// *** common/pes_pkg.sv ***
// Types of the precise event sampling unit
`include "pes_consts.svh"
`default_nettype none
package pes_pkg;
    typedef logic [`PES_CNT_W-1:0]  pes_cnt_t;
    typedef logic [`PES_DATA_W-1:0] pes_word_t;
    typedef logic [`PES_ADDR_W-1:0] pes_addr_t;
    typedef logic [`PES_SEL_W-1:0]  pes_sel_t;

    // Raw facts about one retiring instruction
    typedef struct packed {
        logic       valid;       // An instruction retires this cycle
        logic       is_load;     // It contains a load
        logic       is_store;    // It contains a store
        logic       itlb_miss;   // It missed the instruction TLB
        logic       demand;      // Load is a demand load
        logic       uncore;      // Data came back from the uncore
        logic       l1_hit;
        logic       lfb_hit;
        logic       l2_hit;
        logic       l3_hit;
        logic [3:0] presence;    // Core-presence bits of the L3 line
        logic [3:0] req_core;    // One-hot requesting core
        logic       l3_owned;    // Exclusive or written-back modified in L3
        logic       dram_local;
        logic       dram_remote;
        logic       remote_mod;  // Modified line from another socket
        logic       home_local;  // Home of that line is local
        logic       dtlb_miss;
    } pes_ret_s;

    // Classified event flags of one retiring instruction
    typedef struct packed {
        logic     load;
        logic     store;
        logic     itlb;
        pes_sel_t ld_bits;
        pes_sel_t unc_bits;
    } pes_ev_s;

    typedef enum logic {
        PES_IDLE,
        PES_WRITE
    } pes_state_e;
endpackage
`default_nettype wire

// *** common/pes_class_if.sv ***
// Link between the sampling core and the event classifier
`default_nettype none
interface pes_class_if;
    pes_pkg::pes_ret_s ret;
    pes_pkg::pes_ev_s  ev;

    modport core (output ret, input ev);
    modport clf  (input ret, output ev);
endinterface
`default_nettype wire

// *** src/pes_classify.sv ***
// Classifier of retiring instructions into event flags
`include "pes_consts.svh"
`default_nettype none
module pes_classify (
    pes_class_if.clf cls              // Raw facts in, event flags out
);
    logic nosnoop;
    logic shared;
    logic only_req;
    logic ld_ok;

    always_comb begin
        shared   = (cls.ret.presence & (cls.ret.presence - 4'h1)) != 4'h0;
        only_req = cls.ret.presence == cls.ret.req_core;
        nosnoop  = only_req || shared || cls.ret.l3_owned;  // [R11]
        // Prefetches and ownership reads never reach these flags
        ld_ok    = cls.ret.valid && cls.ret.is_load && cls.ret.demand; // [R8]
    end

    always_comb begin
        cls.ev          = '0;
        cls.ev.load     = cls.ret.valid && cls.ret.is_load;        // [R4]
        cls.ev.store    = cls.ret.valid && cls.ret.is_store;       // [R4]
        cls.ev.itlb     = cls.ret.valid && cls.ret.itlb_miss;      // [R7]
        // Exactly one source flag per retired demand load, none for other loads
        if (ld_ok) begin
            if (cls.ret.l1_hit) begin
                cls.ev.ld_bits = `PES_LD_L1_HIT;                   // [R9]
            end else if (cls.ret.lfb_hit) begin
                cls.ev.ld_bits = `PES_LD_LFB_HIT;                  // [R10]
            end else if (cls.ret.l2_hit) begin
                cls.ev.ld_bits = `PES_LD_L2_HIT;                   // [R10]
            end else if (cls.ret.l3_hit) begin
                cls.ev.ld_bits = nosnoop ? `PES_LD_L3_NOSNP
                                         : `PES_LD_L3_SNP;         // [R10]
            end else begin
                cls.ev.ld_bits = `PES_LD_L3_MISS;                  // [R10]
            end
            // Every missing demand load counts, not only the first to a page
            if (cls.ret.dtlb_miss) begin
                cls.ev.ld_bits = cls.ev.ld_bits | `PES_LD_DTLB_MISS; // [R13]
            end
        end
        if (cls.ret.valid && cls.ret.uncore) begin
            // Remote modified hits are written back, so count as DRAM
            if (cls.ret.dram_local
                || (cls.ret.remote_mod && cls.ret.home_local)) begin
                cls.ev.unc_bits = `PES_UNC_LOCAL;                  // [R12]
            end
            if (cls.ret.dram_remote
                || (cls.ret.remote_mod && !cls.ret.home_local)) begin
                cls.ev.unc_bits = cls.ev.unc_bits | `PES_UNC_REMOTE; // [R12]
            end
        end
    end
endmodule // pes_classify
`default_nettype wire

// *** src/pes_top.sv ***
// Precise event sampling unit: counters, arming, capture, record writer
//
// Behaviour
// R1 - Overflow of a precise counter arms it, and the next matching event captures a sample and signals software.
// R2 - The sampled instruction pointer is the address of the instruction after the eventing one.
// R3 - Each record carries all sixteen general registers as they stand when the eventing instruction completes.
// R4 - Events are only recognised at retirement of loads, stores or other instructions.
// R5 - Any of the four counters can be set to collect samples.
// R6 - Records are stored in memory and the interrupt waits until the record buffer is full.
// R7 - Selection codes pick retired loads, loads by condition, stores, uncore-served memory instructions and instruction TLB misses.
// R8 - Second-level, third-level and DRAM load events count demand loads only; the uncore local and remote DRAM events here are not gated by demand.
// R9 - The per-condition load counts add up exactly to the retired load count. The code counts non-demand loads as retired loads but in no condition count.
// R10 - First-level misses split into fill buffer, second-level, third-level no-snoop, third-level snoop and third-level miss.
// R11 - A third-level hit is no-snoop when only the requester, several sharers, or an owned L3 copy is present.
// R12 - Modified lines from another socket are counted as DRAM-sourced by the local and remote DRAM events.
// R13 - The load data TLB miss event counts every missing load, secondary misses included. The code counts missing demand loads only.
// R14 - Records go to consecutive buffer slots, the position advancing one record per sample.
`include "pes_consts.svh"
`default_nettype none
module pes_top (
    input  wire logic                       clk_sys_i,      // Core clock
    input  wire logic                       srst_i,         // Sync reset
    input  wire pes_pkg::pes_ret_s          ret_i,          // Retiring instr
    input  wire pes_pkg::pes_addr_t         ret_next_ip_i,  // Next ip
    input  wire pes_pkg::pes_word_t [15:0]  ret_gpr_i,      // Registers
    input  wire logic [3:0]                 cnt_en_i,       // Counter on
    input  wire logic [3:0]                 cnt_precise_i,  // Sampling on
    input  wire pes_pkg::pes_sel_t [3:0]    cnt_code_i,     // Event code
    input  wire pes_pkg::pes_sel_t [3:0]    cnt_umask_i,    // Unit mask
    input  wire logic [3:0]                 cnt_load_i,     // Preset strobe
    input  wire pes_pkg::pes_cnt_t          cnt_load_val_i, // Preset value
    output pes_pkg::pes_cnt_t [3:0]         cnt_o,          // Counts
    output logic [3:0]                      armed_o,        // Armed flags
    input  wire pes_pkg::pes_addr_t         buf_base_i,     // Buffer base
    input  wire logic [`PES_RECCNT_W-1:0]   buf_records_i,  // Slots in buffer
    output logic                            mem_req_o,      // Write request
    output pes_pkg::pes_addr_t              mem_addr_o,     // Write address
    output pes_pkg::pes_word_t              mem_wdata_o,    // Write data
    input  wire logic                       mem_ready_i,    // Write taken
    output logic [`PES_RECCNT_W-1:0]        rec_count_o,    // Records held
    output logic                            monitor_interrupt_o, // Buf full
    input  wire logic                       irq_clr_i       // Drain done
);
    pes_class_if cls ();
    pes_classify u_classify (
        .cls (cls)
    );
    assign cls.ret = ret_i;

    // Match of one counter's selection against the current event flags
    function automatic logic sel_hit(input pes_pkg::pes_sel_t code,
                                     input pes_pkg::pes_sel_t umask,
                                     input pes_pkg::pes_ev_s  ev);
        logic hit;
        hit = 1'b0;
        case (code)
            `PES_CODE_MEM_INST: hit = ev.load
                                      && ((umask & `PES_INST_LOADS) != 8'h00);
            `PES_CODE_LD_RET:   hit = (umask & ev.ld_bits) != 8'h00;
            `PES_CODE_UNCORE:   hit = (umask & ev.unc_bits) != 8'h00;
            `PES_CODE_STORE:    hit = ev.store;
            `PES_CODE_ITLB:     hit = ev.itlb;
            default:            hit = 1'b0;
        endcase
        return hit;
    endfunction

    pes_pkg::pes_state_e               state;
    logic [3:0]                        hit;
    logic [3:0]                        take;
    logic                              full;
    logic                              word_done;
    logic                              rec_done;
    logic [`PES_WIDX_W-1:0]            widx;
    pes_pkg::pes_word_t                rec [`PES_REC_WORDS];
    pes_pkg::pes_addr_t                wr_ptr;
    // Shared decodes of the capture side
    logic                              idle;
    logic                              capture;
    logic                              drain_now;
    logic [3:0]                        ovf;

    // Full stalls capture only; counting goes on so no overflow is lost
    assign full      = rec_count_o >= buf_records_i;
    assign idle      = state == pes_pkg::PES_IDLE;
    assign capture   = idle && (|take);
    // Drains land only between records, so a record is never split
    assign drain_now = irq_clr_i && idle;
    assign word_done = (state == pes_pkg::PES_WRITE) && mem_ready_i;
    assign rec_done  = word_done && (widx == `PES_WIDX_LAST);

    genvar g;
    generate
        for (g = 0; g < `PES_NUM_CNT; g++) begin : g_cnt
            always_comb begin
                hit[g]  = cnt_en_i[g]
                          && sel_hit(cnt_code_i[g], cnt_umask_i[g], cls.ev);
                // Only retired events reach hit, so a sample is precise
                take[g] = armed_o[g] && hit[g]
                          && (state == pes_pkg::PES_IDLE) && !full; // [R1] [R4]
                // Overflow is the hit that wraps an all-ones count
                ovf[g]  = hit[g] && cnt_precise_i[g] && !cnt_load_i[g]
                          && (&cnt_o[g]);                    // [R1] [R5]
            end

            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    cnt_o[g] <= '0;
                end else if (cnt_load_i[g]) begin
                    cnt_o[g] <= cnt_load_val_i;
                end else if (hit[g]) begin
                    cnt_o[g] <= cnt_o[g] + `PES_CNT_W'(1);             // [R9]
                end
            end

            // Overflow sets the arm; it wins over a capture clearing it
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    armed_o[g] <= 1'b0;
                end else if (ovf[g]) begin
                    armed_o[g] <= 1'b1;                             // [R1] [R5]
                end else if (take[g] || !cnt_precise_i[g]) begin
                    armed_o[g] <= 1'b0;                                  // [R1]
                end
            end
        end
    endgenerate

    // Capture: counters that fire together share one record, all marked in its status word
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= pes_pkg::PES_IDLE;
        end else begin
            case (state)
                pes_pkg::PES_IDLE: begin
                    if (|take) begin
                        state <= pes_pkg::PES_WRITE;                     // [R1]
                    end
                end
                pes_pkg::PES_WRITE: begin
                    if (rec_done) begin
                        state <= pes_pkg::PES_IDLE;
                    end
                end
                default: state <= pes_pkg::PES_IDLE;
            endcase
        end
    end

    // Record shifts out word by word, so write data always comes from a flop
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            for (int i = 0; i < `PES_REC_WORDS; i++) begin
                rec[i] <= '0;
            end
        end else if (capture) begin
            // Status word: mask of the counters that captured
            rec[0] <= {60'h0, take};
            rec[1] <= {{(`PES_DATA_W-`PES_ADDR_W){1'b0}}, ret_next_ip_i}; // [R2]
            for (int i = 0; i < `PES_NUM_GPR; i++) begin
                rec[i+2] <= ret_gpr_i[i];                                // [R3]
            end
        end else if (word_done) begin
            for (int i = 0; i < `PES_REC_WORDS - 1; i++) begin
                rec[i] <= rec[i+1];
            end
            rec[`PES_REC_WORDS-1] <= '0;
        end
    end

    // Index of the word being offered within the current record
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            widx <= '0;
        end else if (rec_done) begin
            widx <= '0;
        end else if (word_done) begin
            widx <= widx + `PES_WIDX_W'(1);
        end
    end

    // Write position walks the buffer; a drain returns it to the base
    // It never wraps: the full check stops it at the buffer end
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
        end else if (drain_now) begin
            wr_ptr <= buf_base_i;
        end else if (word_done) begin
            wr_ptr <= wr_ptr + `PES_ADDR_W'(`PES_WORD_BYTES);           // [R14]
        end
    end

    // Whole records held; completion and drain never fall in one cycle
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rec_count_o <= '0;
        end else if (rec_done) begin
            rec_count_o <= rec_count_o + `PES_RECCNT_W'(1);             // [R14]
        end else if (drain_now) begin
            rec_count_o <= '0;
        end
    end

    // Interrupt held back until the last slot is written; set beats clear
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            monitor_interrupt_o <= 1'b0;
        end else if (rec_done
                     && (rec_count_o + `PES_RECCNT_W'(1) >= buf_records_i)) begin
            monitor_interrupt_o <= 1'b1;                            // [R1] [R6]
        end else if (irq_clr_i) begin
            monitor_interrupt_o <= 1'b0;
        end
    end

    // Request comes straight from the state flop, so it never glitches
    assign mem_req_o   = state == pes_pkg::PES_WRITE;                    // [R6]
    assign mem_addr_o  = wr_ptr;
    assign mem_wdata_o = rec[0];
endmodule // pes_top
`default_nettype wire

// *** tb/pes_top_sva.sv ***
// Port-level checker of the precise event sampling unit
`include "pes_consts.svh"
`default_nettype none
module pes_top_sva (
    input wire logic                     clk_sys_i,     // Core clock
    input wire logic                     srst_i,        // Sync reset
    input wire logic [3:0]               cnt_precise_i, // Sampling on
    input wire pes_pkg::pes_cnt_t [3:0]  cnt_o,         // Counts
    input wire logic [3:0]               armed_o,       // Arm flags
    input wire logic [`PES_RECCNT_W-1:0] buf_records_i, // Slots
    input wire logic                     mem_req_o,     // Write request
    input wire pes_pkg::pes_addr_t       mem_addr_o,    // Write address
    input wire pes_pkg::pes_word_t       mem_wdata_o,   // Write data
    input wire logic                     mem_ready_i,   // Write taken
    input wire logic [`PES_RECCNT_W-1:0] rec_count_o,   // Records held
    input wire logic                     monitor_interrupt_o, // Full
    input wire logic                     irq_clr_i      // Drain done
);
    timeunit 1ns;
    timeprecision 1ps;
    // Words accepted so far in the record being written
    logic [4:0] wcnt;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !mem_req_o)
            wcnt <= 5'd0;
        else if (mem_ready_i)
            wcnt <= wcnt + 5'd1;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    sequence accept_s;
        mem_req_o && mem_ready_i;
    endsequence
    sequence last_s;
        mem_req_o && mem_ready_i && wcnt == 5'd17;
    endsequence
    reset_clear_a: assert property (disable iff (1'b0) srst_i |=>
        cnt_o == '0 && armed_o == 4'h0 && !mem_req_o && rec_count_o == '0
        && !monitor_interrupt_o) else $error("state not cleared by reset");
    req_hold_a: assert property (mem_req_o && !mem_ready_i |=> mem_req_o
        && $stable(mem_addr_o) && $stable(mem_wdata_o))
        else $error("write request dropped or changed");
    addr_step_a: assert property (accept_s ##1 mem_req_o |->
        mem_addr_o == $past(mem_addr_o) + 48'h8)
        else $error("write address not consecutive");
    rec_len_a: assert property (last_s |=> !mem_req_o &&
        rec_count_o == $past(rec_count_o) + 16'h1)
        else $error("record end or count wrong");
    rec_full_a: assert property ($fell(mem_req_o) && !$past(srst_i) |->
        $past(wcnt) == 5'd17) else $error("record shorter than expected");
    first_word_a: assert property ($rose(mem_req_o) |->
        mem_wdata_o[63:4] == 60'h0 && mem_wdata_o[3:0] != 4'h0)
        else $error("record status word malformed");
    arm_ovf_a: assert property ($rose(armed_o[1]) |->
        cnt_o[1] == '0 && $past(cnt_o[1]) == '1)
        else $error("arm without counter overflow");
    arm_drop_a: assert property (!cnt_precise_i[1] |=> !armed_o[1])
        else $error("arm kept with sampling off");
    irq_full_a: assert property ($rose(monitor_interrupt_o) |->
        rec_count_o == buf_records_i) else $error("interrupt before full");
    irq_hold_a: assert property (monitor_interrupt_o && !irq_clr_i |=>
        monitor_interrupt_o) else $error("interrupt dropped uncleared");
    irq_clear_a: assert property (irq_clr_i && !mem_req_o |=>
        !monitor_interrupt_o) else $error("interrupt not cleared");
endmodule // pes_top_sva
bind pes_top pes_top_sva pes_top_sva_inst (.clk_sys_i, .srst_i,
    .cnt_precise_i, .cnt_o, .armed_o, .buf_records_i, .mem_req_o,
    .mem_addr_o, .mem_wdata_o, .mem_ready_i, .rec_count_o,
    .monitor_interrupt_o, .irq_clr_i);
`default_nettype wire

// *** tb/pes_mem_model.sv ***
// Record memory on the far side of the write port
`default_nettype none
module pes_mem_model (
    input  wire logic               clk_i,       // Core clock
    input  wire logic               rst_i,       // Sync reset
    input  wire logic               slow_i,      // Stall every other cycle
    input  wire logic               mem_req_i,   // Write request
    input  wire pes_pkg::pes_addr_t mem_addr_i,  // Byte address
    input  wire pes_pkg::pes_word_t mem_wdata_i, // Data
    output logic                    mem_ready_o  // Write taken
);
    timeunit 1ns;
    timeprecision 1ps;
    // Small window of memory; upper address bits are ignored
    pes_pkg::pes_word_t mem [128];
    always_ff @(posedge clk_i) begin
        if (mem_req_i && mem_ready_o)
            mem[mem_addr_i[9:3]] <= mem_wdata_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i)
            mem_ready_o <= 1'b0;
        else
            mem_ready_o <= slow_i ? ~mem_ready_o : 1'b1;
    end
endmodule // pes_mem_model
`default_nettype wire

// *** tb/tb_precise_event_sampling_unit.sv ***
// Self-checking bench of the precise event sampling unit
`include "pes_consts.svh"
`default_nettype none
module tb_precise_event_sampling_unit;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        pes_pkg::pes_sel_t code;
        pes_pkg::pes_sel_t umask;
        pes_pkg::pes_ret_s r;
        logic              hit;
    } pes_row_s;
    localparam pes_pkg::pes_sel_t LD = `PES_CODE_LD_RET;
    localparam pes_pkg::pes_addr_t BASE = 48'h100;
    localparam pes_pkg::pes_ret_s EV =
        '{valid:1, is_load:1, demand:1, l2_hit:1, default:0};
    logic                      clk_sys_i, srst_i, req, ready, irq;
    logic                      irq_clr, slow;
    pes_pkg::pes_ret_s         ret_i;
    pes_pkg::pes_addr_t        next_ip, addr;
    pes_pkg::pes_word_t [15:0] gpr;
    logic [3:0]                en, precise, load, armed;
    pes_pkg::pes_sel_t [3:0]   code, umask;
    pes_pkg::pes_cnt_t         load_val;
    pes_pkg::pes_cnt_t [3:0]   cnt;
    pes_pkg::pes_word_t        wdata;
    logic [`PES_RECCNT_W-1:0]  rec_cnt;
    int                        num_errors = 0, total_checks = 0;
    pes_row_s rows [14] = '{
        '{LD, `PES_LD_L2_HIT, EV, 1},
        '{LD, `PES_LD_L2_HIT, '{valid:1, is_load:1, l2_hit:1, default:0}, 0},
        '{LD, `PES_LD_LFB_HIT, '{valid:1, is_load:1, demand:1, lfb_hit:1,
          default:0}, 1},
        '{LD, `PES_LD_L3_NOSNP, '{valid:1, is_load:1, demand:1, l3_hit:1,
          presence:4'h3, req_core:4'h1, default:0}, 1},
        '{LD, `PES_LD_L3_NOSNP, '{valid:1, is_load:1, demand:1, l3_hit:1,
          presence:4'h2, req_core:4'h1, l3_owned:1, default:0}, 1},
        '{LD, `PES_LD_L3_SNP, '{valid:1, is_load:1, demand:1, l3_hit:1,
          presence:4'h2, req_core:4'h1, default:0}, 1},
        '{LD, `PES_LD_L3_MISS, '{valid:1, is_load:1, demand:1,
          dram_local:1, default:0}, 1},
        '{LD, `PES_LD_DTLB_MISS, '{valid:1, is_load:1, demand:1, l1_hit:1,
          dtlb_miss:1, default:0}, 1},
        '{`PES_CODE_UNCORE, `PES_UNC_LOCAL, '{valid:1, is_load:1, demand:1,
          uncore:1, remote_mod:1, home_local:1, default:0}, 1},
        '{`PES_CODE_UNCORE, `PES_UNC_REMOTE, '{valid:1, is_load:1, uncore:1,
          remote_mod:1, default:0}, 1},
        '{`PES_CODE_MEM_INST, `PES_INST_LOADS, EV, 1},
        '{`PES_CODE_STORE, 8'h00, '{valid:1, is_store:1, default:0}, 1},
        '{`PES_CODE_ITLB, 8'h00, '{valid:1, itlb_miss:1, default:0}, 1},
        '{LD, `PES_LD_L2_HIT, '{is_load:1, demand:1, l2_hit:1,
          default:0}, 0}};
    pes_top pes_top_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .ret_i(ret_i), .ret_next_ip_i(next_ip), .ret_gpr_i(gpr),
        .cnt_en_i(en), .cnt_precise_i(precise), .cnt_code_i(code),
        .cnt_umask_i(umask), .cnt_load_i(load), .cnt_load_val_i(load_val),
        .cnt_o(cnt), .armed_o(armed), .buf_base_i(BASE),
        .buf_records_i(16'h2), .mem_req_o(req), .mem_addr_o(addr),
        .mem_wdata_o(wdata), .mem_ready_i(ready), .rec_count_o(rec_cnt),
        .monitor_interrupt_o(irq), .irq_clr_i(irq_clr));
    pes_mem_model pes_mem_model_inst (.clk_i(clk_sys_i), .rst_i(srst_i),
        .slow_i(slow), .mem_req_i(req), .mem_addr_i(addr),
        .mem_wdata_i(wdata), .mem_ready_o(ready));
    task automatic chk_word(input pes_pkg::pes_word_t got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic preset(input logic [3:0] m, input pes_pkg::pes_cnt_t v);
        @(negedge clk_sys_i);
        load = m;
        load_val = v;
        @(negedge clk_sys_i);
        load = 4'h0;
    endtask
    task automatic pulse(input pes_pkg::pes_ret_s r);
        @(negedge clk_sys_i);
        ret_i = r;
        @(negedge clk_sys_i);
        ret_i = '0;
    endtask
    task automatic drain();
        @(negedge clk_sys_i);
        irq_clr = 1'b1;
        @(negedge clk_sys_i);
        irq_clr = 1'b0;
    endtask
    // Overflow arms counter 1, next hit captures; registers then change
    // so a late capture would show wrong values
    task automatic sample(input int k);
        int b;
        b = int'(BASE >> 3) + `PES_REC_WORDS * k;
        preset(4'h2, '1);
        pulse(EV);
        chk_bit(armed[1], 1'b1);
        chk_word(64'(cnt[1]), 64'h0);
        next_ip = 48'h4000 + 48'(k);
        for (int j = 0; j < 16; j++)
            gpr[j] = 64'h100 * 64'(k + 1) + 64'(j);
        pulse(EV);
        next_ip = '1;
        gpr = '1;
        for (int t = 0; t < 200 && rec_cnt !== 16'(k + 1); t++)
            @(negedge clk_sys_i);
        chk_word(64'(rec_cnt), 64'(k + 1));
        chk_word(pes_mem_model_inst.mem[b], 64'h2);
        chk_word(pes_mem_model_inst.mem[b + 1], 64'h4000 + 64'(k));
        for (int j = 0; j < 16; j++)
            chk_word(pes_mem_model_inst.mem[b + 2 + j],
                64'h100 * 64'(k + 1) + 64'(j));
        chk_bit(irq, k == 1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #20000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        {srst_i, irq_clr, slow, load, precise, load_val} = '0;
        srst_i = 1'b1;
        {ret_i, next_ip, gpr, code, umask} = '0;
        en = 4'hF;
        repeat (6) @(negedge clk_sys_i);
        srst_i = 1'b0;
        chk_word(64'(rec_cnt), 64'h0);
        chk_bit(irq, 1'b0);
        drain();
        for (int i = 0; i < 14; i++) begin
            code = {4{rows[i].code}};
            umask = {4{rows[i].umask}};
            preset(4'hF, '0);
            pulse(rows[i].r);
            for (int k = 0; k < 4; k++)
                chk_word(64'(cnt[k]),
                    64'(rows[i].hit));
        end
        // Six demand loads, one source each: the groups add up to the total
        code = {LD, LD, LD, `PES_CODE_MEM_INST};
        umask = {8'h50, 8'h0C, 8'h03, `PES_INST_LOADS};
        preset(4'hF, '0);
        for (int i = 2; i < 8; i++)
            pulse(rows[i].r);
        chk_word(64'(cnt[0]), 64'h6);
        chk_word(64'(cnt[1]), 64'h1);
        chk_word(64'(cnt[2]), 64'h3);
        chk_word(64'(cnt[3]), 64'h2);
        en = 4'h2;
        precise = 4'h2;
        code[1] = LD;
        umask[1] = `PES_LD_L2_HIT;
        sample(0);
        slow = 1'b1;
        sample(1);
        // Buffer full: the hit counts but captures nothing, and the arm survives
        preset(4'h2, '1);
        pulse(EV);
        pulse(EV);
        chk_bit(armed[1], 1'b1);
        chk_word(64'(rec_cnt), 64'h2);
        drain();
        chk_bit(irq, 1'b0);
        chk_word(64'(rec_cnt), 64'h0);
        precise = 4'h0;
        @(negedge clk_sys_i);
        chk_bit(armed[1], 1'b0);
        report_and_stop();
    end
endmodule // tb_precise_event_sampling_unit
`default_nettype wire
